// ### climate_pkg.sv
// constants and types shared by the climate mode sequencer
package climate_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_CYCLES = CLK_HZ;
    localparam int TEMP_W = 8;
    localparam logic [7:0] SET_MIN = 8'h10;      // 16 C
    localparam logic [7:0] SET_MAX = 8'h1E;      // 30 C
    localparam logic [7:0] JUDGE_COOL = 8'h17;   // 23 C
    localparam logic [7:0] JUDGE_DRY = 8'h14;    // 20 C
    localparam logic [7:0] JUDGE_HEAT_COOL = 8'h19; // 25 C
    localparam logic [7:0] STD_COOL = 8'h19;     // 25 C
    localparam logic [7:0] STD_DRY = 8'h16;      // 22 C
    localparam logic [7:0] STD_HEAT = 8'h15;     // 21 C
    localparam logic [7:0] SHIFT_STEP = 8'h02;   // 2 C
    localparam int MIN_RUN_S = 60;
    localparam int RESTART_S = 180;
    localparam int TIME_SAVE_S = 420;
    localparam int DRY_ON_S = 600;
    localparam int DRY_OFF_S = 360;
    localparam int SAMPLE_S = 25;
    localparam int REJUDGE_S = 3600;
    localparam int OFF_LONG_S = 450;
    localparam int SEC_W = 12;
    typedef enum logic [2:0] {MODE_OFF, MODE_COOL, MODE_DRY, MODE_HEAT, MODE_AUTO} mode_e;
    typedef enum logic [1:0] {SHIFT_STD, SHIFT_UP, SHIFT_DN} shift_e;
endpackage : climate_pkg

// ### seconds_tick.sv
// divider that makes the one-second enable pulse
`timescale 1ns/1ps
module seconds_tick #(
    parameter int CYCLES = climate_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);
    logic [31:0] count;

    // free-running count, one pulse per wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 32'h0;
            tick <= 1'b0;
        end else if (count == 32'(CYCLES - 1)) begin
            count <= 32'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule : seconds_tick

// ### room_climate_mode_sequencer.sv
// operating-mode sequencer for the indoor controller of a split air conditioner
// How it works
// - cool/heat target accepted only when inside 16 to 30 C.
// - compressor runs at least 60 s once started.
// - compressor restart blocked for 3 min after each stop.
// - cooling time-save interval lasts at most 7 minutes.
// - soft dry starts only after intake reaches target.
// - soft dry on at most 10 min, off at least 6 min, then thermostat.
// - during dry off hold, after 3 min off, go cooling if intake above on point.
// - automatic start runs fan at lowest sustained step for 25 s first.
// - first judgment: cool at 23 C up, dry 20 to 23, heat below 20.
// - chosen mode runs until off, targets 25, 22, 21 C.
// - re-judge after 1 h if target reached and compressor off over 7.5 min.
// - room not at target after 1 h with compressor running keeps mode.
// - later judgments: cool 23, dry 20, heat 25 thresholds.
// - up/down buttons shift auto targets one 2 C step, no further.
// - open option jumper raises thresholds and standard targets 2 C.
`timescale 1ns/1ps
module room_climate_mode_sequencer #(
    parameter int TICK_CYCLES = climate_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] mode_sel,
    input wire logic [7:0] set_temp,
    input wire logic set_strobe,
    input wire logic temp_up,
    input wire logic temp_down,
    input wire logic [7:0] intake_temp,
    input wire logic temp_offset_option_jumper,
    output logic compressor_run,
    output logic lowest_sustained_fan_step,
    output logic [2:0] active_mode,
    output logic time_save,
    output logic [7:0] target_temp
);
    // ------------------------------------------------------------
    // seconds tick and strap sampling
    // ------------------------------------------------------------
    logic sec;
    logic [2:0] jump_sync;
    logic jumper_open;
    logic [7:0] offs;

    seconds_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(sec)
    );

    // jumper is a pin: three stages, accept when last two agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            jump_sync <= 3'h0;
            jumper_open <= 1'b0;
        end else begin
            jump_sync <= {jump_sync[1:0], temp_offset_option_jumper};
            if (jump_sync[2] == jump_sync[1]) begin
                jumper_open <= jump_sync[2];
            end
        end
    end
    assign offs = jumper_open ? climate_pkg::SHIFT_STEP : 8'h00;

    // ------------------------------------------------------------
    // mode and target selection
    // ------------------------------------------------------------
    climate_pkg::mode_e mode;
    climate_pkg::mode_e run_mode;
    climate_pkg::shift_e shift;
    logic [7:0] user_target;
    logic judged;
    logic first_done;
    localparam int SEC_W_L = climate_pkg::SEC_W;
    logic [SEC_W_L-1:0] sample_cnt;
    logic [SEC_W_L-1:0] hour_cnt;
    logic [SEC_W_L-1:0] off_cnt;
    logic [SEC_W_L-1:0] on_cnt;
    logic reached;
    logic in_auto;

    assign mode = climate_pkg::mode_e'(mode_sel);
    assign in_auto = (mode == climate_pkg::MODE_AUTO);

    // manual target capture
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            user_target <= climate_pkg::STD_COOL;
        end else if (set_strobe && set_temp >= climate_pkg::SET_MIN && set_temp <= climate_pkg::SET_MAX) begin
            user_target <= set_temp;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shift <= climate_pkg::SHIFT_STD;
        end else if (temp_up && !temp_down) begin
            shift <= (shift == climate_pkg::SHIFT_DN) ? climate_pkg::SHIFT_STD : climate_pkg::SHIFT_UP;
        end else if (temp_down && !temp_up) begin
            shift <= (shift == climate_pkg::SHIFT_UP) ? climate_pkg::SHIFT_STD : climate_pkg::SHIFT_DN;
        end
    end

    // target in force for the running mode
    always_comb begin
        logic [7:0] std_t;
        std_t = climate_pkg::STD_COOL;
        if (in_auto) begin
            unique case (run_mode)
                climate_pkg::MODE_DRY: std_t = climate_pkg::STD_DRY;
                climate_pkg::MODE_HEAT: std_t = climate_pkg::STD_HEAT;
                default: std_t = climate_pkg::STD_COOL;
            endcase
            std_t = std_t + offs;
            unique case (shift)
                climate_pkg::SHIFT_UP: target_temp = std_t + climate_pkg::SHIFT_STEP;
                climate_pkg::SHIFT_DN: target_temp = std_t - climate_pkg::SHIFT_STEP;
                default: target_temp = std_t;
            endcase
        end else begin
            target_temp = user_target;
        end
    end

    // heating is satisfied at or above target, cooling and dry at or below
    assign reached = (run_mode == climate_pkg::MODE_HEAT) ? (intake_temp >= target_temp)
                                                          : (intake_temp <= target_temp);

    // automatic judgment: sampling, first and later decisions
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_mode <= climate_pkg::MODE_OFF;
            judged <= 1'b0;
            first_done <= 1'b0;
            sample_cnt <= '0;
            hour_cnt <= '0;
        end else if (!in_auto) begin
            run_mode <= mode;
            judged <= 1'b0;
            first_done <= 1'b0;
            sample_cnt <= '0;
            hour_cnt <= '0;
        end else if (!judged) begin
            run_mode <= climate_pkg::MODE_OFF;
            // sample period on lowest fan step
            if (sec) begin
                sample_cnt <= sample_cnt + 1'b1;
            end
            if (sample_cnt == SEC_W_L'(climate_pkg::SAMPLE_S)) begin
                judged <= 1'b1;
                hour_cnt <= '0;
                sample_cnt <= '0;
                if (!first_done) begin
                    if (intake_temp >= climate_pkg::JUDGE_COOL + offs) begin
                        run_mode <= climate_pkg::MODE_COOL;
                    end else if (intake_temp >= climate_pkg::JUDGE_DRY + offs) begin
                        run_mode <= climate_pkg::MODE_DRY;
                    end else begin
                        run_mode <= climate_pkg::MODE_HEAT;
                    end
                end
                first_done <= 1'b1;
            end
        end else begin
            if (sec && hour_cnt != SEC_W_L'(climate_pkg::REJUDGE_S)) begin
                hour_cnt <= hour_cnt + 1'b1;
            end
            // re-judge only when satisfied and compressor long off
            if (hour_cnt == SEC_W_L'(climate_pkg::REJUDGE_S) && reached && !compressor_run
                    && off_cnt > SEC_W_L'(climate_pkg::OFF_LONG_S)) begin
                hour_cnt <= '0;
                unique case (run_mode)
                    climate_pkg::MODE_COOL: run_mode <= (intake_temp >= climate_pkg::JUDGE_COOL + offs)
                        ? climate_pkg::MODE_COOL : climate_pkg::MODE_HEAT;
                    climate_pkg::MODE_DRY: run_mode <= (intake_temp >= climate_pkg::JUDGE_DRY + offs)
                        ? climate_pkg::MODE_DRY : climate_pkg::MODE_HEAT;
                    default: run_mode <= (intake_temp >= climate_pkg::JUDGE_HEAT_COOL + offs)
                        ? climate_pkg::MODE_COOL : climate_pkg::MODE_HEAT;
                endcase
            end
        end
    end

    assign lowest_sustained_fan_step = in_auto && !judged;

    // ------------------------------------------------------------
    // compressor timers and soft dry cycling
    // ------------------------------------------------------------
    logic demand;
    logic dry_started;
    logic dry_first_on;
    logic dry_hold;
    logic [SEC_W_L-1:0] dry_cnt;
    logic dry_cool;
    logic may_stop;
    logic may_start;

    // a dry escape runs as plain cooling, so it is reported as cooling
    assign active_mode = dry_cool ? climate_pkg::MODE_COOL : run_mode;

    assign may_stop = on_cnt >= SEC_W_L'(climate_pkg::MIN_RUN_S);
    assign may_start = off_cnt >= SEC_W_L'(climate_pkg::RESTART_S);

    // thermostat demand per mode
    always_comb begin
        demand = 1'b0;
        unique case (run_mode)
            climate_pkg::MODE_COOL: demand = intake_temp > target_temp;
            climate_pkg::MODE_HEAT: demand = intake_temp < target_temp;
            climate_pkg::MODE_DRY: begin
                if (dry_cool) begin
                    demand = intake_temp > target_temp;
                end else if (dry_first_on) begin
                    demand = 1'b1;
                end else if (dry_hold) begin
                    demand = 1'b0;
                end else begin
                    demand = dry_started && intake_temp > target_temp;
                end
            end
            default: demand = 1'b0;
        endcase
    end

    // soft dry phase tracking
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dry_started <= 1'b0;
            dry_first_on <= 1'b0;
            dry_hold <= 1'b0;
            dry_cnt <= '0;
            dry_cool <= 1'b0;
        end else if (run_mode != climate_pkg::MODE_DRY) begin
            dry_started <= 1'b0;
            dry_first_on <= 1'b0;
            dry_hold <= 1'b0;
            dry_cnt <= '0;
            dry_cool <= 1'b0;
        end else if (!dry_started) begin
            // wait for intake to reach target
            if (intake_temp <= target_temp) begin
                dry_started <= 1'b1;
                dry_first_on <= 1'b1;
                dry_cnt <= '0;
            end
        end else if (dry_first_on) begin
            if (sec) begin
                dry_cnt <= dry_cnt + 1'b1;
            end
            if (dry_cnt >= SEC_W_L'(climate_pkg::DRY_ON_S - 1) && sec) begin
                dry_first_on <= 1'b0;
                dry_hold <= 1'b1;
                dry_cnt <= '0;
            end
        end else if (dry_hold) begin
            if (sec) begin
                dry_cnt <= dry_cnt + 1'b1;
            end
            if (may_start && !compressor_run && intake_temp > target_temp) begin
                dry_cool <= 1'b1;
                dry_hold <= 1'b0;
            end else if (dry_cnt >= SEC_W_L'(climate_pkg::DRY_OFF_S)) begin
                dry_hold <= 1'b0;
            end
        end
    end

    // compressor run with on and off second counters
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            compressor_run <= 1'b0;
            on_cnt <= '0;
            off_cnt <= SEC_W_L'(climate_pkg::RESTART_S);
        end else if (compressor_run) begin
            if (sec && on_cnt != '1) begin
                on_cnt <= on_cnt + 1'b1;
            end
            if (!demand && may_stop) begin
                compressor_run <= 1'b0;
                off_cnt <= '0;
            end
        end else begin
            if (sec && off_cnt != '1) begin
                off_cnt <= off_cnt + 1'b1;
            end
            if (demand && may_start) begin
                compressor_run <= 1'b1;
                on_cnt <= '0;
            end
        end
    end

    // time-save window: first 7 min of each run while run_mode is cooling, so not during a dry escape
    assign time_save = compressor_run && run_mode == climate_pkg::MODE_COOL
                       && on_cnt < SEC_W_L'(climate_pkg::TIME_SAVE_S);
endmodule : room_climate_mode_sequencer

// ### climate_checker.sv
// assertions on the climate sequencer ports
`timescale 1ns/1ps
module climate_checker #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [2:0] mode_sel,
    input wire logic compressor_run,
    input wire logic lowest_sustained_fan_step,
    input wire logic [2:0] active_mode,
    input wire logic time_save,
    input wire logic [7:0] target_temp
);
    localparam int T = TICK_CYCLES;
    int on_cnt;
    int off_cnt;
    int fan_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----------------
    // run, idle and sampling lengths
    // ----------------
    // idle preloaded long, since the first start may be immediate
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            on_cnt <= 0;
            off_cnt <= 1_000_000;
            fan_cnt <= 0;
        end else begin
            on_cnt <= compressor_run ? on_cnt + 1 : 0;
            off_cnt <= compressor_run ? 0 : off_cnt + 1;
            fan_cnt <= lowest_sustained_fan_step ? fan_cnt + 1 : 0;
        end
    end
    // bounds allow one tick of slack for the divider phase
    // minimum run
    a_min_run_time: assert property ($fell(compressor_run) |->
        on_cnt >= (climate_pkg::MIN_RUN_S - 1) * T) else $error("compressor stopped early");
    a_restart_hold: assert property ($rose(compressor_run) |->
        off_cnt >= (climate_pkg::RESTART_S - 1) * T) else $error("compressor restarted early");
    a_time_save_window: assert property (time_save |-> active_mode == climate_pkg::MODE_COOL &&
        on_cnt <= (climate_pkg::TIME_SAVE_S + 1) * T) else $error("time save out of window");
    a_fan_sample_len: assert property ($fell(lowest_sustained_fan_step) |->
        fan_cnt >= (climate_pkg::SAMPLE_S - 1) * T) else $error("sampling too short");
    a_fan_mode_idle: assert property (lowest_sustained_fan_step |->
        active_mode == climate_pkg::MODE_OFF && !compressor_run) else $error("mode during sampling");
    a_auto_mode_chosen: assert property ($fell(lowest_sustained_fan_step) |->
        ##[0:1] active_mode != climate_pkg::MODE_OFF) else $error("no mode after sampling");
    a_target_in_range: assert property (target_temp >= climate_pkg::SET_MIN &&
        target_temp <= climate_pkg::SET_MAX) else $error("target out of range");
    a_manual_mode_run: assert property ((mode_sel == 3'h1 || mode_sel == 3'h3) [*3] |->
        active_mode == mode_sel) else $error("mode not followed");
endmodule : climate_checker
bind room_climate_mode_sequencer climate_checker #(.TICK_CYCLES(TICK_CYCLES)) u_climate_checker (
    .clk(clk), .rstn(rstn), .mode_sel(mode_sel), .compressor_run(compressor_run),
    .lowest_sustained_fan_step(lowest_sustained_fan_step), .active_mode(active_mode),
    .time_save(time_save), .target_temp(target_temp));

// ### remote_sensor_model.sv
// stand-in for the remote receiver and the intake air sensor
`timescale 1ns/1ps
module remote_sensor_model (
    input wire logic clk,
    output logic [2:0] mode_sel,
    output logic [7:0] set_temp,
    output logic set_strobe,
    output logic temp_up,
    output logic temp_down,
    output logic [7:0] intake_temp,
    output logic temp_offset_option_jumper
);
    // idle levels at time zero
    initial begin
        mode_sel = 3'h0;
        set_temp = 8'h00;
        set_strobe = 1'b0;
        temp_up = 1'b0;
        temp_down = 1'b0;
        intake_temp = 8'h18;
        temp_offset_option_jumper = 1'b0;
    end
    // one-cycle key; data inverted afterwards so a stale value never counts
    task automatic key(input logic [1:0] k, input logic [7:0] t);
        @(negedge clk);
        set_temp = t;
        set_strobe = (k == 2'h0);
        temp_up = (k == 2'h1);
        temp_down = (k == 2'h2);
        @(negedge clk);
        set_strobe = 1'b0;
        temp_up = 1'b0;
        temp_down = 1'b0;
        set_temp = ~t;
        @(negedge clk);
    endtask : key
    // mode and air level changes on the falling edge, jumper pin at once
    task automatic mode(input logic [2:0] m);
        @(negedge clk);
        mode_sel = m;
    endtask : mode
    task automatic air(input logic [7:0] t);
        @(negedge clk);
        intake_temp = t;
    endtask : air
    task automatic pin(input logic j);
        temp_offset_option_jumper = j;
    endtask : pin
endmodule : remote_sensor_model

// ### test_room_climate_mode_sequencer.sv
// self-checking bench for the climate mode sequencer
`timescale 1ns/1ps
module test_room_climate_mode_sequencer;
    localparam int TICK = 4;
    logic clk;
    logic rstn;
    logic [2:0] mode_sel;
    logic [7:0] set_temp;
    logic set_strobe;
    logic temp_up;
    logic temp_down;
    logic [7:0] intake_temp;
    logic jmp;
    logic comp;
    logic fan;
    logic [2:0] am;
    logic ts;
    logic [7:0] tgt;
    int failures;
    int n_tests;
    room_climate_mode_sequencer #(.TICK_CYCLES(TICK)) u_room_climate_mode_sequencer (.clk(clk), .rstn(rstn),
        .mode_sel(mode_sel), .set_temp(set_temp), .set_strobe(set_strobe), .temp_up(temp_up),
        .temp_down(temp_down), .intake_temp(intake_temp), .temp_offset_option_jumper(jmp),
        .compressor_run(comp), .lowest_sustained_fan_step(fan), .active_mode(am), .time_save(ts),
        .target_temp(tgt));
    remote_sensor_model u_remote_sensor_model (.clk(clk), .mode_sel(mode_sel), .set_temp(set_temp),
        .set_strobe(set_strobe), .temp_up(temp_up), .temp_down(temp_down), .intake_temp(intake_temp),
        .temp_offset_option_jumper(jmp));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic secs(input int n);
        repeat (n * TICK) @(negedge clk);
    endtask : secs
    // mode off first so no stale selection survives the reset
    task automatic restart();
        u_remote_sensor_model.mode(3'h0);
        rstn = 1'b0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        check(8'(comp), 8'h00);
        check(8'(am), 8'h00);
        check(8'(ts), 8'h00);
        check(tgt, 8'h19);
    endtask : restart
    task automatic t_cool();
        restart();
        u_remote_sensor_model.mode(3'h1);
        u_remote_sensor_model.key(2'h0, 8'h0F);
        check(tgt, 8'h19);
        u_remote_sensor_model.key(2'h0, 8'h1F);
        check(tgt, 8'h19);
        u_remote_sensor_model.key(2'h0, 8'h10);
        check(tgt, 8'h10);
        u_remote_sensor_model.key(2'h0, 8'h1E);
        check(tgt, 8'h1E);
        u_remote_sensor_model.key(2'h0, 8'h14);
        u_remote_sensor_model.air(8'h1C);
        secs(2);
        check(8'(comp), 8'h01);
        check(8'(ts), 8'h01);
        u_remote_sensor_model.air(8'h0A);
        secs(55);
        check(8'(comp), 8'h01);
        secs(10);
        check(8'(comp), 8'h00);
        u_remote_sensor_model.air(8'h1C);
        secs(170);
        check(8'(comp), 8'h00);
        secs(15);
        check(8'(comp), 8'h01);
        secs(430);
        check(8'(ts), 8'h00);
        $display("t_cool done");
    endtask : t_cool
    task automatic t_auto();
        logic [19:0] cases [5] = '{20'h01719, 20'h01416, 20'h01315, 20'h11818, 20'h1191B};
        foreach (cases[i]) begin
            u_remote_sensor_model.pin(cases[i][16]);
            restart();
            u_remote_sensor_model.air(cases[i][15:8]);
            u_remote_sensor_model.mode(3'h4);
            secs(22);
            check(8'(fan), 8'h01);
            check(8'(am), 8'h00);
            secs(6);
            check(8'(fan), 8'h00);
            check(8'(am), i == 2 ? 8'h03 : (i == 4 || i == 0) ? 8'h01 : 8'h02);
            check(tgt, cases[i][7:0]);
        end
        // jumper still open: raised cooling standard plus one up step
        u_remote_sensor_model.key(2'h1, 8'h00);
        check(tgt, 8'h1D);
        u_remote_sensor_model.pin(1'b0);
        $display("t_auto done");
    endtask : t_auto
    task automatic t_shift();
        restart();
        u_remote_sensor_model.air(8'h1A);
        u_remote_sensor_model.mode(3'h4);
        secs(28);
        repeat (2) u_remote_sensor_model.key(2'h1, 8'h00);
        check(tgt, 8'h1B);
        repeat (3) u_remote_sensor_model.key(2'h2, 8'h00);
        check(tgt, 8'h17);
        $display("t_shift done");
    endtask : t_shift
    task automatic t_rejudge();
        restart();
        u_remote_sensor_model.air(8'h1E);
        u_remote_sensor_model.mode(3'h4);
        secs(3648);
        check(8'(am), 8'h01);
        check(8'(comp), 8'h01);
        u_remote_sensor_model.air(8'h0A);
        secs(65);
        check(8'(comp), 8'h00);
        secs(470);
        check(8'(am), 8'h03);
        check(tgt, 8'h15);
        $display("t_rejudge done");
    endtask : t_rejudge
    task automatic t_dry();
        restart();
        u_remote_sensor_model.air(8'h28);
        u_remote_sensor_model.mode(3'h2);
        secs(10);
        check(8'(comp), 8'h00);
        u_remote_sensor_model.air(8'h0A);
        secs(3);
        check(8'(comp), 8'h01);
        secs(600);
        check(8'(comp), 8'h00);
        secs(300);
        u_remote_sensor_model.air(8'h28);
        secs(3);
        check(8'(am), 8'h01);
        check(8'(comp), 8'h01);
        $display("t_dry done");
    endtask : t_dry
    // manual heating: target taken, immediate first start, minimum run
    task automatic t_heat();
        restart();
        u_remote_sensor_model.key(2'h0, 8'h16);
        u_remote_sensor_model.air(8'h12);
        u_remote_sensor_model.mode(3'h3);
        secs(2);
        check(8'(am), 8'h03);
        check(tgt, 8'h16);
        check(8'(comp), 8'h01);
        check(8'(ts), 8'h00);
        u_remote_sensor_model.air(8'h1A);
        secs(50);
        check(8'(comp), 8'h01);
        secs(15);
        check(8'(comp), 8'h00);
        $display("t_heat done");
    endtask : t_heat
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    // tests need about 24000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        results();
    end
    initial begin
        rstn = 1'b0;
        failures = 0;
        n_tests = 0;
        t_cool();
        t_auto();
        t_shift();
        t_rejudge();
        t_dry();
        t_heat();
        results();
    end
endmodule : test_room_climate_mode_sequencer
